// >>> rtl/smb_cfg.svh
// bit positions, reset values and sizes of the mode burst sequencer
// assumes: included by the sequencer file
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH
`define SMB_BL_LSB     0
`define SMB_BL_MSB     2
`define SMB_ORD_BIT    3
`define SMB_RL_LSB     4
`define SMB_RL_MSB     6
`define SMB_OM_LSB     7
`define SMB_OM_MSB     8
`define SMB_WSGL_BIT   9
`define SMB_RSV_LSB    10
`define SMB_MODE_W     14
`define SMB_MODE_RST   14'h0000
`define SMB_BL_FULL    3'h7
`define SMB_PAGE_WORDS 9'h100
`define SMB_FIFO_DEPTH 16
`define SMB_FIFO_W     10
`endif

// >>> rtl/smb_pkg.sv
// types of the mode burst sequencer
// assumes: smb_cfg.svh on the include path
package smb_pkg;
  // command code {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    SMB_CMD_LMR = 3'h0,
    SMB_CMD_WR  = 3'h4,
    SMB_CMD_RD  = 3'h5,
    SMB_CMD_BST = 3'h6
  } smb_cmd_type;
  typedef enum logic {
    SMB_ST_IDLE = 1'b0,
    SMB_ST_RUN  = 1'b1
  } smb_state_type;
endpackage

// >>> rtl/smb_sequencer.sv
// column fifo and mode register burst sequencer
// assumes: command pins arrive from outside the i_mclk domain
`include "smb_cfg.svh"

// ********************************
// fifo
// ********************************
module smb_fifo #(
  parameter int WIDTH = `SMB_FIFO_W,
  parameter int DEPTH = `SMB_FIFO_DEPTH
) (
  input  wire logic             i_mclk,
  input  wire logic             i_arst_n,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign o_ready = (wr_q - rd_q) != DEPTH[AW:0];
  assign o_valid = wr_q != rd_q;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule // smb_fifo

// ********************************
// sequencer
// ********************************
module smb_sequencer (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [1:0]  i_ba,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_col_ready,
  output logic             o_col_valid,
  output logic      [7:0]  o_col_addr,
  output logic             o_col_write,
  output logic             o_col_last,
  output logic             o_dq_oe_n,
  output logic             o_rd_valid,
  output logic             o_burst_busy,
  output logic      [8:0]  o_burst_words,
  output logic      [1:0]  o_read_latency,
  output logic             o_cfg_reserved
);
  import smb_pkg::*;

  // ********************************
  // decode helpers
  // ********************************
  function automatic logic [8:0] bl_words(input logic [2:0] c);
    case (c)
      3'h0:         bl_words = 9'h001;
      3'h1:         bl_words = 9'h002;
      3'h2:         bl_words = 9'h004;
      3'h3:         bl_words = 9'h008;
      `SMB_BL_FULL: bl_words = `SMB_PAGE_WORDS;
      default:      bl_words = 9'h001;
    endcase
  endfunction

  function automatic logic [7:0] col_at(input logic [7:0] s, input logic [7:0] i,
                                        input logic [7:0] m, input logic il);
    logic [7:0] o;
    o = il ? (s ^ i) : (s + i);
    col_at = (s & ~m) | (o & m);
  endfunction

  // ********************************
  // pin synchroniser
  // ********************************
  logic [17:0] sync1_q;
  logic [17:0] sync2_q;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= 18'h20000;
      sync2_q <= 18'h20000;
    end else begin
      sync1_q <= {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr};
      sync2_q <= sync1_q;
    end
  end

  smb_cmd_type cmd;
  logic        sel;
  logic        lmr_evt;
  logic        rd_evt;
  logic        wr_evt;
  logic        bst_evt;
  assign cmd     = smb_cmd_type'(sync2_q[16:14]);
  assign sel     = !sync2_q[17];
  assign lmr_evt = sel && cmd == SMB_CMD_LMR && sync2_q[13:12] == 2'h0;
  assign rd_evt  = sel && cmd == SMB_CMD_RD;
  assign wr_evt  = sel && cmd == SMB_CMD_WR;
  assign bst_evt = sel && cmd == SMB_CMD_BST;

  // ********************************
  // mode register
  // ********************************
  logic [`SMB_MODE_W-1:0] mode_q;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= `SMB_MODE_RST;
    end else if (lmr_evt) begin
      mode_q <= sync2_q[13:0];
    end
  end

  logic [2:0] bl_code;
  logic       il_req;
  logic [2:0] rl_code;
  assign bl_code        = mode_q[`SMB_BL_MSB:`SMB_BL_LSB];
  assign il_req         = mode_q[`SMB_ORD_BIT];
  assign rl_code        = mode_q[`SMB_RL_MSB:`SMB_RL_LSB];
  assign o_burst_words  = bl_words(bl_code);
  assign o_read_latency = (rl_code == 3'h1 || rl_code == 3'h2) ? rl_code[1:0] : 2'h3;
  assign o_cfg_reserved = (bl_code[2] && bl_code != `SMB_BL_FULL)
                        || (bl_code == `SMB_BL_FULL && il_req)
                        || rl_code == 3'h0 || rl_code[2]
                        || mode_q[`SMB_OM_MSB:`SMB_OM_LSB] != 2'h0
                        || mode_q[`SMB_MODE_W-1:`SMB_RSV_LSB] != 4'h0;

  bl_decode_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (bl_code == 3'h3 |-> o_burst_words == 9'h008)
    and (bl_code == 3'h7 |-> o_burst_words == 9'h100)
    and (bl_code == 3'h0 |-> o_burst_words == 9'h001))
    else $error("burst length decode wrong");
  mode_rsv_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (mode_q[8:7] != 2'h0 || mode_q[6:4] == 3'h0) |-> o_cfg_reserved)
    else $error("reserved mode not flagged");

  // ********************************
  // column generator
  // ********************************
  smb_state_type state_q;
  logic [7:0]    start_q;
  logic [8:0]    len_q;
  logic          il_q;
  logic          wr_q;
  logic [7:0]    idx_q;
  logic          fifo_in_ready;
  logic          push_valid;
  logic          push_fire;
  logic          push_last;
  logic [7:0]    push_col;
  logic [8:0]    cap_len;
  logic [7:0]    mask;

  // single location for writes when the write single bit is set
  assign cap_len    = (wr_evt && mode_q[`SMB_WSGL_BIT]) ? 9'h001 : o_burst_words;
  assign mask       = 8'(len_q - 9'h001);
  assign push_valid = state_q == SMB_ST_RUN;
  assign push_fire  = push_valid && fifo_in_ready;
  assign push_last  = {1'b0, idx_q} == len_q - 9'h001;
  assign push_col   = col_at(start_q, idx_q, mask, il_q);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_q <= 8'h00;
      len_q   <= 9'h001;
      il_q    <= 1'b0;
      wr_q    <= 1'b0;
    end else if (rd_evt || wr_evt) begin
      start_q <= sync2_q[7:0];
      len_q   <= cap_len;
      il_q    <= il_req && bl_code != `SMB_BL_FULL;
      wr_q    <= wr_evt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= SMB_ST_IDLE;
      idx_q   <= 8'h00;
    end else if (rd_evt || wr_evt) begin
      state_q <= SMB_ST_RUN;
      idx_q   <= 8'h00;
    end else if (bst_evt) begin
      state_q <= SMB_ST_IDLE;
    end else if (push_fire) begin
      idx_q <= idx_q + 8'h01;
      if (push_last) begin
        state_q <= SMB_ST_IDLE;
      end
    end
  end

  assign o_burst_busy = push_valid;

  smb_fifo #(
    .WIDTH (`SMB_FIFO_W),
    .DEPTH (`SMB_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_valid  (push_valid),
    .o_ready  (fifo_in_ready),
    .i_data   ({push_last, wr_q, push_col}),
    .o_valid  (o_col_valid),
    .i_ready  (i_col_ready),
    .o_data   ({o_col_last, o_col_write, o_col_addr})
  );

  len_max_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    push_valid |-> {1'b0, idx_q} < len_q)
    else $error("burst ran past its length");
  block_keep_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    push_valid |-> (push_col & ~mask) == (start_q & ~mask))
    else $error("burst left its block");
  page_seq_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (push_valid && len_q == 9'h100) |-> !il_q)
    else $error("full page burst interleaved");
  single_col_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (push_valid && len_q == 9'h001) |-> push_col == start_q)
    else $error("single burst column wrong");
  seq_step_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (push_fire && !push_last && !il_q && !rd_evt && !wr_evt && !bst_evt)
    |=> push_col == ((start_q & ~mask) | (($past(push_col) + 8'h01) & mask)))
    else $error("sequential step wrong");
  inter_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (push_valid && il_q) |-> ((push_col ^ start_q) & mask) == (idx_q & mask))
    else $error("interleaved order wrong");
  wsingle_len_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (wr_evt && mode_q[9]) |=> len_q == 9'h001)
    else $error("write single mode ignored");
  hold_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (push_valid && !rd_evt && !wr_evt) |=> $stable(start_q) && $stable(len_q))
    else $error("burst settings changed mid burst");
  start_col_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    rd_evt |=> start_q == $past(sync2_q[7:0]))
    else $error("start column not captured");

  // ********************************
  // read latency
  // ********************************
  logic       rd1_q;
  logic       rd2_q;
  logic       drv_q;
  logic [8:0] rd_len_q;
  logic [8:0] rvcnt_q;
  logic       drv_d;

  assign drv_d = (o_read_latency == 2'h1 && rd_evt)
               || (o_read_latency == 2'h2 && rd1_q)
               || (o_read_latency == 2'h3 && rd2_q);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd1_q    <= 1'b0;
      rd2_q    <= 1'b0;
      drv_q    <= 1'b0;
      rd_len_q <= 9'h001;
    end else begin
      rd1_q <= rd_evt;
      rd2_q <= rd1_q;
      drv_q <= drv_d && !bst_evt;
      if (rd_evt) begin
        rd_len_q <= o_burst_words;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvcnt_q <= 9'h000;
    end else if (bst_evt) begin
      rvcnt_q <= 9'h000;
    end else if (drv_q) begin
      rvcnt_q <= rd_len_q;
    end else if (rvcnt_q != 9'h000) begin
      rvcnt_q <= rvcnt_q - 9'h001;
    end
  end

  assign o_rd_valid = rvcnt_q != 9'h000;
  assign o_dq_oe_n  = !(drv_q || o_rd_valid);

  lat_two_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (rd_evt && o_read_latency == 2'h2 && !o_rd_valid && !drv_q && !rd1_q)
    ##1 (!bst_evt && !rd_evt) [*2] |-> !o_dq_oe_n && !o_rd_valid ##1 o_rd_valid)
    else $error("latency two timing wrong");
  rd_field_a : assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (mode_q[6:4] == 3'h1) |-> o_read_latency == 2'h1)
    else $error("latency field misplaced");
endmodule // smb_sequencer

// >>> sim/smb_ctl_model.sv
// holds: memory controller model driving the command and address pins
// assumes: tasks are entered at a falling edge of i_mclk
module smb_ctl_model
  import smb_pkg::*;
(
  input  wire logic        i_mclk,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic      [1:0]  o_ba,
  output logic      [11:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // command issue
  // ****************************************
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_ba = 2'h0;
    o_addr = 12'h000;
  end
  // one command cycle; the bench loads the mode only with no burst running
  // latency choice suits a 10 MHz clock for every code
  task automatic issue(input smb_cmd_type cmd, input logic [1:0] ba, input logic [11:0] addr);
    o_cs_n = 1'b0;
    {o_ras_n, o_cas_n, o_we_n} = cmd;
    o_ba = ba;
    o_addr = (cmd == SMB_CMD_LMR) ? {2'h0, addr[9:0]} : addr;
    @(negedge i_mclk);
    // released lines show the inverse, not the last value
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = ~cmd;
    o_ba = ~ba;
    o_addr = ~addr;
  endtask
endmodule // smb_ctl_model

// >>> sim/tb.sv
// holds: self-checking bench of the mode register burst sequencer
// assumes: design and controller model compiled before it
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import smb_pkg::*;
  logic        mclk, arst_n, cs_n, ras_n, cas_n, we_n, col_ready;
  logic        col_valid, col_write, col_last, dq_oe_n, rd_valid, busy, rsv;
  logic [1:0]  ba, rl;
  logic [11:0] addr;
  logic [7:0]  col_addr;
  logic [8:0]  words;
  logic [9:0]  got_q[$];
  int          fails, n_checks, cyc;
  smb_ctl_model ctl_u (.i_mclk(mclk), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
  smb_sequencer dut_u (.i_mclk(mclk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_col_ready(col_ready),
    .o_col_valid(col_valid), .o_col_addr(col_addr), .o_col_write(col_write),
    .o_col_last(col_last), .o_dq_oe_n(dq_oe_n), .o_rd_valid(rd_valid),
    .o_burst_busy(busy), .o_burst_words(words), .o_read_latency(rl), .o_cfg_reserved(rsv));
  // ****************************************
  // clock, column sink, timeout
  // ****************************************
  always #50 mclk = ~mclk;
  always @(negedge mclk) col_ready <= ($urandom % 4) != 0;
  always @(posedge mclk) begin
    cyc++;
    if (col_valid === 1'b1 && col_ready === 1'b1) got_q.push_back({col_last, col_write, col_addr});
    if (cyc == 40000) begin
      fails++;
      close_out();
    end
  end
  // ****************************************
  // expectations and tasks
  // ****************************************
  function automatic logic [8:0] words_of(logic [2:0] c);
    case (c)
      3'h1: return 9'h002;
      3'h2: return 9'h004;
      3'h3: return 9'h008;
      3'h7: return 9'h100;
      default: return 9'h001;
    endcase
  endfunction
  function automatic logic [1:0] rl_of(logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h3) ? c[1:0] : 2'h3;
  endfunction
  function automatic logic rsv_of(logic [9:0] m);
    return (m[2:0] inside {3'h4, 3'h5, 3'h6}) || (m[2:0] == 3'h7 && m[3]) ||
           !(m[6:4] inside {3'h1, 3'h2, 3'h3}) || m[8:7] != 2'h0;
  endfunction
  function automatic logic [7:0] col_of(logic [7:0] st, logic [8:0] w, logic il, int i);
    logic [7:0] mk;
    mk = 8'(w - 9'h1);
    return (st & ~mk) | ((il && w != 9'h100) ? ((st ^ 8'(i)) & mk) : ((st + 8'(i)) & mk));
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic lmr(input logic [1:0] b, input logic [9:0] m);
    ctl_u.issue(SMB_CMD_LMR, b, {2'h0, m});
    repeat (3) @(negedge mclk);
  endtask
  task automatic burst(input logic [9:0] m, input logic wr, input logic [7:0] st);
    int n;
    int k;
    logic [8:0] w;
    lmr(2'h0, m);
    w = (wr && m[9]) ? 9'h001 : words_of(m[2:0]);
    got_q.delete();
    ctl_u.issue(wr ? SMB_CMD_WR : SMB_CMD_RD, 2'($urandom), {4'($urandom), st});
    repeat (2) @(negedge mclk);
    if (!wr) begin
      chk(dq_oe_n, rl_of(m[6:4]) != 2'h1);
      repeat (int'(rl_of(m[6:4])) - 1) @(negedge mclk);
      chk(dq_oe_n, 1'b0);
      chk(rd_valid, 1'b0);
      @(negedge mclk);
      n = 0;
      while (rd_valid === 1'b1 && n < 300) begin
        n++;
        @(negedge mclk);
      end
      chk(16'(n), 16'(w));
      chk(dq_oe_n, 1'b1);
    end
    k = 0;
    while ((busy !== 1'b0 || col_valid !== 1'b0) && k < 1000) begin
      k++;
      @(negedge mclk);
    end
    if (k == 1000) fails++;
    chk(16'(got_q.size()), 16'(w));
    foreach (got_q[i]) chk(got_q[i], {i == w - 1, wr, col_of(st, w, m[3], i)});
  endtask
  // full page burst cut by a terminate d cycles after the read or write
  task automatic stop(input logic [9:0] m, input logic wr, input logic [7:0] st, input int d);
    lmr(2'h0, m);
    got_q.delete();
    ctl_u.issue(wr ? SMB_CMD_WR : SMB_CMD_RD, 2'h1, {4'h0, st});
    repeat (d - 1) @(negedge mclk);
    ctl_u.issue(SMB_CMD_BST, 2'h1, 12'h000);
    @(negedge mclk);
    chk(rd_valid, !wr);
    @(negedge mclk);
    chk({busy, rd_valid, dq_oe_n}, 3'h1);
    while (col_valid !== 1'b0) @(negedge mclk);
    chk(16'(got_q.size()), 16'(d));
    foreach (got_q[i]) chk(got_q[i], {1'b0, wr, col_of(st, 9'h100, 1'b0, i)});
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [9:0] m;
    logic [2:0] bl;
    mclk = 1'b0;
    arst_n = 1'b0;
    void'($urandom(32'h3c8bd98a));
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    chk(words, 9'h001);
    chk(rl, 2'h3);
    chk(rsv, 1'b1);
    for (int i = 0; i < 128; i++) begin
      m = {1'b0, (i % 9 == 4) ? 2'(i % 3 + 1) : 2'h0, 7'(i)};
      lmr(2'h0, m);
      chk(words, words_of(m[2:0]));
      chk(rl, rl_of(m[6:4]));
      chk(rsv, rsv_of(m));
    end
    lmr(2'h0, 10'h01a);
    lmr(2'h2, 10'h003);
    chk(words, 9'h004);
    burst(10'h022, 1'b0, 8'h05);
    burst(10'h03b, 1'b0, 8'h5d);
    burst(10'h017, 1'b1, 8'h9c);
    burst(10'h012, 1'b0, 8'h7e);
    burst(10'h219, 1'b1, 8'h37);
    burst(10'h219, 1'b0, 8'h37);
    burst(10'h018, 1'b0, 8'hff);
    stop(10'h017, 1'b1, 8'hfd, 6);
    stop(10'h027, 1'b0, 8'h10, 9);
    stop(10'h037, 1'b0, 8'h40, 4 + int'($urandom % 8));
    for (int i = 0; i < 24; i++) begin
      bl = ($urandom % 5 == 4) ? 3'h7 : 3'($urandom % 4);
      m = {1'($urandom), 2'h0, 3'($urandom % 3 + 1), (bl == 3'h7) ? 1'b0 : 1'($urandom), bl};
      burst(m, 1'($urandom), 8'($urandom));
    end
    close_out();
  end
endmodule // tb
